// ==== rtl/periodic_timebase_interrupt.sv ====
// periodic timebase: divider counter, overflow flag and interrupt, register port
//
// How it works
// RQ1 - The counter advances on each oscillator clock rising edge, optionally through a divide-by-128 prescale.
// RQ2 - While timebase_enable is zero the divider counter is held at zero.
// RQ3 - Once timebase_enable is one the divider counter starts incrementing.
// RQ4 - The read-only timebase_flag is set whenever the counter overflows at the tap picked by rate_select.
// RQ5 - An interrupt is requested while timebase_flag and timebase_irq_enable are both one.
// RQ6 - Writing one to flag_acknowledge clears timebase_flag; writing zero does nothing.
// RQ7 - flag_acknowledge is write-only and always reads back as zero.
// RQ8 - The first event after enabling comes at about half the period, the later ones at the full period.
// RQ9 - Without prescale, codes 000 to 111 give taps 32768, 8192, 2048, 128, 64, 32, 16 and 8.
// RQ10 - With the prescale each tap is 128 times longer, from 4194304 down to 1024.
// RQ11 - The event period is the divider value over the counter input clock frequency.
// RQ12 - Software must disable the timebase before changing rate_select.
// RQ13 - In stop mode the counter runs only if osc_run_in_stop is set, otherwise it is idle.
// RQ14 - The counter keeps running in wait mode, and the register is closed to the CPU in wait and stop.
// RQ15 - Reset clears timebase_enable and timebase_irq_enable.
// RQ16 - Software restarts the count from zero by clearing and then setting timebase_enable.
// RQ17 - timebase_flag stays set until acknowledged, and an overflow that meets an acknowledge keeps it set.
//
// Local design decisions: strobed register access and the address map.

`timescale 1ns/1ps
`default_nettype none

module periodic_timebase_interrupt #(
  parameter int unsigned COUNT_W = tbm_pkg::CNT_W
) (
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        ce_i,
  input  wire logic [tbm_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [tbm_pkg::DATA_W-1:0]  wr_data_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [tbm_pkg::DATA_W-1:0]  rd_data_o,
  input  wire logic                        oscillator_clock_i,
  input  wire logic                        extra_prescale_select_i,
  input  wire logic                        osc_run_in_stop_i,
  input  wire logic                        wait_mode_i,
  input  wire logic                        stop_mode_i,
  output logic                             irq_o,
  output logic                             wakeup_o
);

  // the widest tap with prescale sits at bit COUNT_W-1
  initial begin
    if (COUNT_W != tbm_pkg::CNT_W) begin
      $error("COUNT_W must equal the divider chain length");
    end
  end

  tbm_pkg::bus_req_s req;
  tbm_pkg::ctrl_s    ctrl_ff;
  tbm_pkg::ctrl_s    nxt_ctrl;

  logic                          osc_prev_ff;
  logic                          osc_rise;
  logic                          counter_active;
  logic                          count_tick;
  logic [COUNT_W-1:0]            div_cnt_ff;
  logic [COUNT_W-1:0]            nxt_div_cnt;
  logic [4:0]                    tap_idx;
  logic                          tap_event;
  logic                          flag_ff;
  logic [tbm_pkg::EVT_W-1:0]     irq_status_ff;
  logic [tbm_pkg::EVT_W-1:0]     irq_mask_ff;
  logic                          bus_open;
  logic                          wr_ctrl;
  logic                          wr_status;
  logic                          wr_mask;
  logic                          ack;
  logic                          irq_cond;
  logic [tbm_pkg::DATA_W-1:0]    nxt_rd_data;
  logic [tbm_pkg::DATA_W-1:0]    ctrl_view;

  assign req.addr  = addr_i;
  assign req.wdata = wr_data_i;
  assign req.wr    = wr_i;
  assign req.rd    = rd_i;

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------

  // the cpu cannot reach the register while in a low power mode
  assign bus_open = ~wait_mode_i & ~stop_mode_i; // RQ14

  assign wr_ctrl   = req.wr & bus_open & (req.addr == tbm_pkg::OFS_CTRL);
  assign wr_status = req.wr & bus_open & (req.addr == tbm_pkg::OFS_IRQ_STATUS);
  assign wr_mask   = req.wr & bus_open & (req.addr == tbm_pkg::OFS_IRQ_MASK);

  // only a one in the acknowledge position acts
  assign ack = wr_ctrl & req.wdata[tbm_pkg::BIT_ACK]; // RQ6

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl.rate_select =
        req.wdata[tbm_pkg::RATE_LSB +: tbm_pkg::RATE_W];
      nxt_ctrl.timebase_irq_enable = req.wdata[tbm_pkg::BIT_IRQ_EN];
      nxt_ctrl.timebase_enable     = req.wdata[tbm_pkg::BIT_ENABLE];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= tbm_pkg::ctrl_s'(tbm_pkg::CTRL_RST[4:0]); // RQ15
    end else if (ce_i) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ---------------------------------------------------------------
  // oscillator edge and counter
  // ---------------------------------------------------------------

  // the oscillator input is sampled on the system clock, so it must be
  // well below half of sys_clk for no edge to be missed
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_prev_ff <= 1'b0;
    end else if (ce_i) begin
      osc_prev_ff <= oscillator_clock_i;
    end
  end

  assign osc_rise = oscillator_clock_i & ~osc_prev_ff; // RQ1

  // wait mode does not stop it; stop mode does unless the oscillator runs
  assign counter_active = ~stop_mode_i | osc_run_in_stop_i; // RQ13 RQ14

  assign count_tick = osc_rise & counter_active & ctrl_ff.timebase_enable; // RQ3

  assign nxt_div_cnt = div_cnt_ff + {{(COUNT_W-1){1'b0}}, 1'b1};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_ff <= '0;
    end else if (ce_i) begin
      if (!ctrl_ff.timebase_enable) begin
        div_cnt_ff <= '0; // RQ2 RQ16
      end else if (count_tick) begin
        div_cnt_ff <= nxt_div_cnt; // RQ3
      end
    end
  end

  // one chain serves both clock choices: the prescale just moves every tap
  // seven stages further up, multiplying each period by 128
  always_comb begin
    tap_idx = tbm_pkg::TAP_LOG2[ctrl_ff.rate_select] - 5'h01; // RQ9
    if (extra_prescale_select_i) begin
      tap_idx = tap_idx + 5'(tbm_pkg::PRESCALE_LOG2); // RQ10 RQ1
    end
  end

  // an event is the rise of the bit below the tap: from zero that comes after
  // half a period, then once every full period of divider/f_in
  assign tap_event = count_tick & ~div_cnt_ff[tap_idx] & nxt_div_cnt[tap_idx]; // RQ4 RQ8 RQ11

  // ---------------------------------------------------------------
  // flag and interrupt status
  // ---------------------------------------------------------------

  // set beats acknowledge so an overflow in the same cycle is kept
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_ff <= 1'b0;
    end else if (ce_i) begin
      if (tap_event) begin
        flag_ff <= 1'b1; // RQ4 RQ17
      end else if (ack) begin
        flag_ff <= 1'b0; // RQ6 RQ17
      end
    end
  end

  // sticky event record, write one to clear, new event wins
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status_ff <= tbm_pkg::IRQ_STATUS_RST[tbm_pkg::EVT_W-1:0];
    end else if (ce_i) begin
      if (tap_event) begin
        irq_status_ff[tbm_pkg::BIT_EVT_TICK] <= 1'b1;
      end else if (wr_status) begin
        irq_status_ff <= irq_status_ff & ~req.wdata[tbm_pkg::EVT_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_ff <= tbm_pkg::IRQ_MASK_RST[tbm_pkg::EVT_W-1:0];
    end else if (ce_i) begin
      if (wr_mask) begin
        irq_mask_ff <= req.wdata[tbm_pkg::EVT_W-1:0];
      end
    end
  end

  assign irq_cond = (flag_ff & ctrl_ff.timebase_irq_enable) |
                    (|(irq_status_ff & irq_mask_ff)); // RQ5

  // registered outputs add one cycle of latency to the request
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= irq_cond; // RQ5
    end
  end

  // the request doubles as the wakeup source while stopped
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wakeup_o <= 1'b0;
    end else if (ce_i) begin
      wakeup_o <= irq_cond & stop_mode_i; // RQ13
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  always_comb begin
    ctrl_view = '0;
    ctrl_view[tbm_pkg::BIT_FLAG] = flag_ff;
    ctrl_view[tbm_pkg::RATE_LSB +: tbm_pkg::RATE_W] = ctrl_ff.rate_select;
    ctrl_view[tbm_pkg::BIT_ACK] = 1'b0; // RQ7
    ctrl_view[tbm_pkg::BIT_IRQ_EN] = ctrl_ff.timebase_irq_enable;
    ctrl_view[tbm_pkg::BIT_ENABLE] = ctrl_ff.timebase_enable;
  end

  always_comb begin
    nxt_rd_data = '0;
    if (req.rd && bus_open) begin // RQ14
      unique case (req.addr)
        tbm_pkg::OFS_CTRL: begin
          nxt_rd_data = ctrl_view;
        end
        tbm_pkg::OFS_IRQ_STATUS: begin
          nxt_rd_data[tbm_pkg::EVT_W-1:0] = irq_status_ff;
        end
        tbm_pkg::OFS_IRQ_MASK: begin
          nxt_rd_data[tbm_pkg::EVT_W-1:0] = irq_mask_ff;
        end
        default: begin
          nxt_rd_data = '0;
        end
      endcase
    end
  end

  // data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else if (ce_i) begin
      rd_data_o <= nxt_rd_data;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/tbm_pkg.sv ====
// shared constants, register layout and carrier types for the periodic timebase
package tbm_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [1:0] OFS_CTRL       = 2'h0;
  localparam logic [1:0] OFS_IRQ_STATUS = 2'h1;
  localparam logic [1:0] OFS_IRQ_MASK   = 2'h2;

  // timebase_control field positions
  localparam int unsigned BIT_FLAG     = 7;
  localparam int unsigned RATE_LSB     = 4;
  localparam int unsigned RATE_W       = 3;
  localparam int unsigned BIT_ACK      = 3;
  localparam int unsigned BIT_IRQ_EN   = 2;
  localparam int unsigned BIT_ENABLE   = 1;

  // interrupt status / mask field positions
  localparam int unsigned BIT_EVT_TICK = 0;
  localparam int unsigned EVT_W        = 1;

  // reset values
  localparam logic [7:0] CTRL_RST       = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST   = 8'h00;

  // divider chain: 15 selectable stages plus an optional divide-by-128 prescale
  localparam int unsigned DIV_STAGES    = 15;
  localparam int unsigned PRESCALE_LOG2 = 7;
  localparam int unsigned CNT_W         = DIV_STAGES + PRESCALE_LOG2;

  // log2 of the divider tap for each rate code, no prescale
  localparam logic [4:0] TAP_LOG2 [8] = '{5'h0f, 5'h0d, 5'h0b, 5'h07,
                                          5'h06, 5'h05, 5'h04, 5'h03};

  // system clock figures
  localparam int unsigned SYS_CLK_HZ = 125_000_000;
  localparam int unsigned SYS_CLK_NS = 8;

  typedef struct packed {
    logic [2:0] rate_select;
    logic       timebase_irq_enable;
    logic       timebase_enable;
  } ctrl_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;

endpackage

// ==== verif/periodic_timebase_interrupt_assertions.sv ====
// port-level checker for the periodic timebase
`timescale 1ns/1ps
`default_nettype none
module periodic_timebase_interrupt_assertions #(
  parameter int unsigned COUNT_W = tbm_pkg::CNT_W
) (
  input wire logic                       sys_clk_i,
  input wire logic                       rst_n_i,
  input wire logic                       ce_i,
  input wire logic [tbm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [tbm_pkg::DATA_W-1:0] wr_data_i,
  input wire logic                       wr_i,
  input wire logic                       rd_i,
  input wire logic [tbm_pkg::DATA_W-1:0] rd_data_o,
  input wire logic                       oscillator_clock_i,
  input wire logic                       extra_prescale_select_i,
  input wire logic                       osc_run_in_stop_i,
  input wire logic                       wait_mode_i,
  input wire logic                       stop_mode_i,
  input wire logic                       irq_o,
  input wire logic                       wakeup_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_rd_idle_zero: assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
    else $error("read data outside its answer cycle");
  chk_ack_reads_zero: assert property ($past(rd_i) && $past(addr_i) == tbm_pkg::OFS_CTRL |->
    rd_data_o[tbm_pkg::BIT_ACK] == 1'b0 && rd_data_o[0] == 1'b0) else $error("write-only bit read back");
  chk_port_closed: assert property ($past(rd_i) && ($past(wait_mode_i) || $past(stop_mode_i)) |->
    rd_data_o == 8'h00) else $error("register readable in low power");
  chk_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) == 2'h3 |-> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  chk_wake_needs_stop: assert property (!$past(stop_mode_i) |-> !wakeup_o)
    else $error("wakeup outside stop");
  chk_wake_with_irq: assert property (wakeup_o |-> irq_o)
    else $error("wakeup without interrupt");
  chk_irq_rise_cause: assert property ($rose(irq_o) |-> $past(wr_i) || $past(wr_i, 2) ||
    !$past(stop_mode_i, 2) || $past(osc_run_in_stop_i, 2)) else $error("interrupt rose while frozen");
  chk_irq_fall_cause: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3))
    else $error("interrupt dropped with no write");
endmodule
bind periodic_timebase_interrupt periodic_timebase_interrupt_assertions #(.COUNT_W(COUNT_W)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .oscillator_clock_i(oscillator_clock_i),
  .extra_prescale_select_i(extra_prescale_select_i), .osc_run_in_stop_i(osc_run_in_stop_i),
  .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i), .irq_o(irq_o), .wakeup_o(wakeup_o));
`default_nettype wire

// ==== verif/periodic_timebase_interrupt_tb.sv ====
// self-checking bench for the periodic timebase
`timescale 1ns/1ps
`default_nettype none
module periodic_timebase_interrupt_tb;
  logic       clk = 0, rst_n = 0, ce = 1, wr = 0, rd = 0, osc = 0, pre = 0, ris = 0, wt = 0, stp = 0;
  logic [1:0] addr = '0;
  logic [7:0] wd = '0;
  logic [7:0] rdat;
  logic       irq, wake;
  int         n_errors = 0, total_checks = 0, cyc = 0, b;

  periodic_timebase_interrupt u_periodic_timebase_interrupt (
    .sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .addr_i(addr), .wr_data_i(wd), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rdat), .oscillator_clock_i(osc), .extra_prescale_select_i(pre), .osc_run_in_stop_i(ris),
    .wait_mode_i(wt), .stop_mode_i(stp), .irq_o(irq), .wakeup_o(wake));

  always #4 clk = ~clk;
  // oscillator at half the system rate: one rising edge, so one count, every two cycles
  always @(posedge clk) osc <= ~osc;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wd <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp, input string what);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 chk(what, {24'h0, exp}, {24'h0, rdat});
  endtask
  // bounded wait for the interrupt level; t is the cycle it was seen
  task automatic wait_irq(input logic lvl, input int lim, output int t);
    int k;
    k = 0;
    #1;
    while (irq !== lvl && k < lim) begin @(posedge clk); #1; k++; end
    t = cyc;
    chk("irq", {31'h0, lvl}, {31'h0, irq});
  endtask
  function automatic int tap_of(input logic [2:0] rt, input logic p);
    int t [8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
    return p ? t[rt] * 128 : t[rt];
  endfunction
  task automatic run_rate(input logic [2:0] rt, input logic p);
    int tap, a, c;
    tap = tap_of(rt, p);
    @(posedge clk) pre <= p;
    wr_reg(2'h0, {1'b0, rt, 4'h0});
    wr_reg(2'h0, {1'b0, rt, 4'h6});
    a = cyc;
    wait_irq(1'b1, tap * 2, b);
    chk("first event", 1, 32'((b - a) >= tap - 4 && (b - a) <= tap + 6));
    rd_reg(2'h0, {1'b1, rt, 4'h6}, "ctrl flag set");
    wr_reg(2'h0, {1'b0, rt, 4'he});
    rd_reg(2'h0, {1'b0, rt, 4'h6}, "ctrl after ack");
    wait_irq(1'b1, tap * 3, c);
    chk("period", tap * 2, c - b);
    wr_reg(2'h0, {1'b0, rt, 4'h8});
    rd_reg(2'h0, {1'b0, rt, 4'h0}, "ctrl off");
  endtask

  initial begin
    void'($urandom(32'hd476));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(2'h0, 8'h00, "ctrl reset");
    @(posedge clk) wt <= 1'b1;
    wr_reg(2'h0, 8'($urandom) | 8'h06);
    rd_reg(2'h0, 8'h00, "ctrl in wait");
    @(posedge clk) wt <= 1'b0;
    wr_reg(2'h3, 8'($urandom));
    rd_reg(2'h3, 8'h00, "unmapped");
    rd_reg(2'h0, 8'h00, "ctrl kept");
    for (int r = 7; r >= 1; r--) run_rate(3'(r), 1'b0);
    run_rate(3'h7, 1'b1);
    @(posedge clk) pre <= 1'b0;
    wr_reg(2'h0, 8'h76);
    @(posedge clk) stp <= 1'b1;
    repeat (64) @(posedge clk);
    #1 chk("irq frozen in stop", 0, {31'h0, irq});
    @(posedge clk) ris <= 1'b1;
    wait_irq(1'b1, 40, b);
    @(posedge clk) #1 chk("wakeup", 1, {31'h0, wake});
    @(posedge clk) stp <= 1'b0;
    wr_reg(2'h0, 8'h7e);
    @(posedge clk) wt <= 1'b1;
    wait_irq(1'b1, 40, b);
    @(posedge clk) wt <= 1'b0;
    // sticky status with its mask, flag interrupt disabled
    wr_reg(2'h0, 8'h7a);
    wr_reg(2'h1, 8'h01);
    wr_reg(2'h2, 8'h01);
    rd_reg(2'h2, 8'h01, "mask");
    wait_irq(1'b1, 40, b);
    rd_reg(2'h1, 8'h01, "status");
    wr_reg(2'h1, 8'h01);
    wait_irq(1'b0, 4, b);
    // a low clock enable must drop the strobe: the mask keeps its value
    @(posedge clk) ce <= 1'b0;
    wr_reg(2'h2, 8'h00);
    @(posedge clk) ce <= 1'b1;
    rd_reg(2'h2, 8'h01, "mask frozen by ce");
    results();
  end
endmodule
`default_nettype wire
